// File: hdl/serial_bus_phy_link_power_ctrl.sv
// phy link side: parallel capture, data-strobe tx/rx, repeat, port gating,
// self-id bits, gap count and link power management behind apb
// assumes the link runs on link_clk from this block and cable pins are async
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
//
// Contract
// - latch 2, 4 or 8 link data lines on the system clock
// - serialise captured bits into a data-strobe stream at three rates; the code shifts one bit per pclk at every speed
// - receiving port has transmitters off and receivers on
// - decode received stream, deserialise to 2/4/8 lines, hand to link
// - repeat received packet out of all other active connected ports
// - disabled, suspended or disconnected port keeps tx and rx off
// - port without cable stays disconnected per connect detect
// - contender in self-id bit 20, power class in bits 21 to 23
// - gap counts must match; two bus resets return gap to 3Fh
// - power status low 1.2 to 25 us resets link interface
// - power status low over 25 us disables interface, repeating continues
// - interface off and link-on packet: toggle wake signal to link
// - power status active again re-enables the link interface
// - wake signal stops once link active control bit is set
module serial_bus_phy_link_power_ctrl
  import phy_link_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic link_clk,
  input wire logic [7:0] link_tx_data,
  input wire logic link_tx_valid,
  output logic link_tx_ready,
  output logic [7:0] link_rx_data,
  output logic link_rx_valid,
  input wire logic link_power_status,
  input wire logic link_on_detect,
  output logic link_if_reset,
  output logic link_if_enabled,
  output logic link_wake_signal,
  input wire logic [2:0] port_data_in,
  input wire logic [2:0] port_strobe_in,
  input wire logic [2:0] port_connect,
  output logic [2:0] port_data_out,
  output logic [2:0] port_strobe_out,
  output logic [2:0] port_tx_oe_n,
  output logic [2:0] port_rx_en,
  input wire logic [2:0] power_class_inputs,
  input wire logic bm_contender,
  input wire logic bus_reset_in
);
  typedef struct packed {
    logic [1:0] speed;
    logic link_active;
    logic [2:0] port_en;
    logic [2:0] port_susp;
    logic [5:0] gap;
    logic reset_seen;
    logic bus_rst_prev;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] ser_word;
    logic [3:0] ser_left;
    logic enc_data;
    logic enc_strobe;
    logic [2:0] tx_oe_n;
    logic [2:0] rx_en;
    logic [1:0] rx_port;
    logic [3:0] rx_idle;
    logic [2:0] rx_prev;
    logic [7:0] des_word;
    logic [3:0] des_cnt;
    logic [7:0] rx_out;
    logic rx_valid;
    logic [9:0] lps_cnt;
    lif_state_type lif;
    logic if_reset;
    logic if_enabled;
    logic wake;
    logic [3:0] wake_cnt;
    logic wake_out;
    logic clk_div;
  } phy_state_type;

  phy_state_type s;
  phy_state_type next_s;
  logic [13:0] sync_out;
  logic [2:0] rxd;
  logic [2:0] rxs;
  logic [2:0] conn;
  logic [2:0] pc;
  logic cont;
  logic brst;
  logic [2:0] act;
  logic [2:0] edge_seen;
  logic [3:0] nbits;
  logic [7:0] lane_mask;
  logic acc;
  logic take;
  logic f_valid;
  logic f_ready;
  logic f_in_valid;
  logic [7:0] f_data;
  logic fifo_in_ready;
  logic sending;
  logic bit_go;
  logic bit_val;
  logic got;
  logic rbit;
  logic [1:0] gate_port;

  // cable and strap pins pass two flops first
  sync2 #(.WIDTH(14)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({bus_reset_in, bm_contender, power_class_inputs, port_connect,
          port_strobe_in, port_data_in}),
    .dout(sync_out)
  );

  assign rxd = sync_out[2:0];
  assign rxs = sync_out[5:3];
  assign conn = sync_out[8:6];
  assign pc = sync_out[11:9];
  assign cont = sync_out[12];
  assign brst = sync_out[13];

  assign act = s.port_en & ~s.port_susp & conn;
  assign edge_seen = (rxd ^ rxs) ^ s.rx_prev;
  assign nbits = lines_for(s.speed);
  assign lane_mask = (8'h01 << nbits) - 8'h01;
  assign acc = psel && penable;
  assign take = acc && s.pready;
  assign f_in_valid = link_tx_valid && s.if_enabled && !s.if_reset;
  assign f_ready = (s.ser_left == 4'h0) && (s.rx_port == PORT_NONE);
  assign sending = (s.ser_left != 4'h0) || f_valid;

  phy_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(f_in_valid),
    .in_data(link_tx_data & lane_mask),
    .in_ready(fifo_in_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );

  always_comb begin
    next_s = s;
    bit_go = 1'b0;
    bit_val = 1'b0;
    got = 1'b0;
    rbit = 1'b0;
    next_s.rx_valid = 1'b0;
    next_s.clk_div = ~s.clk_div;

    // apb: one wait state, read data and error latched with pready
    next_s.pready = acc && !s.pready;
    if (acc && !s.pready) begin
      next_s.pslverr = 1'b0;
      case (paddr)
        ADDR_CTRL: begin
          next_s.prdata = (32'(s.speed) << CTRL_SPEED_LSB)
                        | (32'(s.link_active) << CTRL_LACT_BIT)
                        | (32'(s.port_en) << CTRL_PEN_LSB)
                        | (32'(s.port_susp) << CTRL_PSUS_LSB);
        end
        ADDR_STATUS: begin
          next_s.prdata = (32'(s.lif) << ST_LIF_LSB)
                        | (32'(s.wake) << ST_WAKE_BIT)
                        | (32'(conn) << ST_CONN_LSB)
                        | (32'(act) << ST_ACT_LSB)
                        | (32'(s.rx_port) << ST_RXP_LSB);
        end
        ADDR_SELFID: begin
          next_s.prdata = (32'(cont) << SELFID_CONT_BIT)
                        | (32'(pc) << SELFID_PC_LSB);
        end
        ADDR_GAP: begin
          next_s.prdata = 32'(s.gap);
        end
        default: begin
          next_s.prdata = 32'h0000_0000;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    if (take && pwrite) begin
      case (paddr)
        ADDR_CTRL: begin
          next_s.speed = pwdata[CTRL_SPEED_LSB +: 2];
          next_s.link_active = pwdata[CTRL_LACT_BIT];
          next_s.port_en = pwdata[CTRL_PEN_LSB +: 3];
          next_s.port_susp = pwdata[CTRL_PSUS_LSB +: 3];
        end
        ADDR_GAP: begin
          next_s.gap = pwdata[5:0];
          next_s.reset_seen = 1'b0;
        end
        default: begin
          next_s.gap = next_s.gap;
        end
      endcase
    end

    // second bus reset with no gap write between restores the maximum
    next_s.bus_rst_prev = brst;
    if (brst && !s.bus_rst_prev) begin
      if (s.reset_seen) begin
        next_s.gap = GAP_MAX;
      end
      next_s.reset_seen = 1'b1;
    end

    // serializer, msb of the lane group first
    if (f_valid && f_ready) begin
      next_s.ser_word = f_data;
      next_s.ser_left = nbits;
    end else if (s.ser_left != 4'h0) begin
      bit_go = 1'b1;
      bit_val = s.ser_word[3'(s.ser_left - 4'd1)];
      next_s.ser_left = s.ser_left - 4'd1;
    end

    // receive: pick first active port that toggles while idle
    next_s.rx_prev = rxd ^ rxs;
    if (s.rx_port == PORT_NONE) begin
      for (int i = NUM_PORTS - 1; i >= 0; i--) begin
        if (edge_seen[i] && act[i] && s.ser_left == 4'h0) begin
          next_s.rx_port = 2'(i);
          got = 1'b1;
          rbit = rxd[i];
        end
      end
    end else begin
      if (edge_seen[s.rx_port]) begin
        got = 1'b1;
        rbit = rxd[s.rx_port];
      end else if (s.rx_idle == RX_IDLE_CYC - 4'd1) begin
        next_s.rx_port = PORT_NONE;
        next_s.rx_idle = 4'h0;
        next_s.des_cnt = 4'h0;
      end else begin
        next_s.rx_idle = s.rx_idle + 4'd1;
      end
    end
    if (got) begin
      next_s.rx_idle = 4'h0;
      bit_go = 1'b1;
      bit_val = rbit;
      next_s.des_word = {s.des_word[6:0], rbit};
      if (s.des_cnt + 4'd1 == nbits) begin
        next_s.des_cnt = 4'h0;
        next_s.rx_out = {s.des_word[6:0], rbit} & lane_mask;
        next_s.rx_valid = s.if_enabled && !s.if_reset;
      end else begin
        next_s.des_cnt = s.des_cnt + 4'd1;
      end
    end

    // data-strobe encoder: strobe flips when data repeats
    if (bit_go) begin
      next_s.enc_data = bit_val;
      next_s.enc_strobe = (bit_val == s.enc_data) ? ~s.enc_strobe : s.enc_strobe;
    end

    // port driver and receiver enables; gated from the start edge so bit one repeats
    gate_port = (s.rx_port != PORT_NONE) ? s.rx_port : next_s.rx_port;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (gate_port != PORT_NONE) begin
        next_s.tx_oe_n[i] = !(act[i] && (2'(i) != gate_port));
        next_s.rx_en[i] = act[i] && (2'(i) == gate_port);
      end else begin
        next_s.tx_oe_n[i] = !(act[i] && sending);
        next_s.rx_en[i] = act[i] && !sending;
      end
    end

    // link power status watch
    if (link_power_status) begin
      next_s.lps_cnt = 10'h000;
    end else if (s.lps_cnt <= LPS_DIS_CYC) begin
      next_s.lps_cnt = s.lps_cnt + 10'd1;
    end
    case (s.lif)
      LIF_ON: begin
        if (!link_power_status && next_s.lps_cnt > LPS_RST_CYC) begin
          next_s.lif = LIF_RESET;
        end
      end
      LIF_RESET: begin
        if (link_power_status) begin
          next_s.lif = LIF_ON;
        end else if (next_s.lps_cnt > LPS_DIS_CYC) begin
          next_s.lif = LIF_OFF;
        end
      end
      LIF_OFF: begin
        if (link_power_status) begin
          next_s.lif = LIF_ON;
        end
      end
      default: begin
        next_s.lif = LIF_ON;
      end
    endcase
    next_s.if_reset = next_s.lif == LIF_RESET;
    next_s.if_enabled = next_s.lif != LIF_OFF;

    // wake toggling while the link is off
    if (!s.if_enabled && link_on_detect) begin
      next_s.wake = 1'b1;
    end
    if (s.link_active) begin
      next_s.wake = 1'b0;
    end
    if (next_s.wake) begin
      if (s.wake_cnt >= WAKE_HALF_CYC - 4'd1) begin
        next_s.wake_cnt = 4'h0;
        next_s.wake_out = ~s.wake_out;
      end else begin
        next_s.wake_cnt = s.wake_cnt + 4'd1;
      end
    end else begin
      next_s.wake_cnt = 4'h0;
      next_s.wake_out = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.port_en <= PORT_EN_RST;
      s.gap <= GAP_MAX;
      s.rx_port <= PORT_NONE;
      s.tx_oe_n <= 3'h7;
      s.lif <= LIF_ON;
      s.if_enabled <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign link_clk = s.clk_div;
  assign link_tx_ready = fifo_in_ready;
  assign link_rx_data = s.rx_out;
  assign link_rx_valid = s.rx_valid;
  assign link_if_reset = s.if_reset;
  assign link_if_enabled = s.if_enabled;
  assign link_wake_signal = s.wake_out;
  assign port_data_out = {3{s.enc_data}};
  assign port_strobe_out = {3{s.enc_strobe}};
  assign port_tx_oe_n = s.tx_oe_n;
  assign port_rx_en = s.rx_en;

  property p_ds_step;
    @(posedge pclk) disable iff (!presetn)
      bit_go |=> ((s.enc_data ^ s.enc_strobe) != $past(s.enc_data ^ s.enc_strobe));
  endproperty
  a_ds_step: assert property (p_ds_step) else $error("ds stream missed a bit");

  property p_rx_port_gate;
    @(posedge pclk) disable iff (!presetn)
      (s.rx_port != PORT_NONE) |=> (port_tx_oe_n[$past(s.rx_port)]
        && (port_rx_en[$past(s.rx_port)] == $past(act[s.rx_port])));
  endproperty
  a_rx_port_gate: assert property (p_rx_port_gate) else $error("rx port drives");

  property p_deliver;
    @(posedge pclk) disable iff (!presetn)
      (got && (s.des_cnt + 4'd1 == nbits) && s.if_enabled && !s.if_reset)
        |=> link_rx_valid;
  endproperty
  a_deliver: assert property (p_deliver) else $error("rx word not delivered");

  property p_off_port;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> (((port_rx_en | ~port_tx_oe_n) & ~$past(act)) == 3'h0);
  endproperty
  a_off_port: assert property (p_off_port) else $error("inactive port enabled");

  property p_disc;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> ((port_tx_oe_n | $past(conn)) == 3'h7);
  endproperty
  a_disc: assert property (p_disc) else $error("unplugged port driven");

  property p_selfid;
    @(posedge pclk) disable iff (!presetn)
      (acc && !s.pready && paddr == ADDR_SELFID)
        |=> (prdata[23:20] == {$past(pc), $past(cont)});
  endproperty
  a_selfid: assert property (p_selfid) else $error("self-id bits wrong");

  property p_gap;
    @(posedge pclk) disable iff (!presetn)
      (brst && !s.bus_rst_prev && s.reset_seen) |=> (s.gap == GAP_MAX);
  endproperty
  a_gap: assert property (p_gap) else $error("gap not restored");

  property p_lps_reset;
    @(posedge pclk) disable iff (!presetn)
      (s.lps_cnt > LPS_RST_CYC && s.lps_cnt <= LPS_DIS_CYC) |-> link_if_reset;
  endproperty
  a_lps_reset: assert property (p_lps_reset) else $error("interface not reset");

  property p_lps_off;
    @(posedge pclk) disable iff (!presetn)
      (s.lps_cnt > LPS_DIS_CYC) |-> (!link_if_enabled && !link_if_reset);
  endproperty
  a_lps_off: assert property (p_lps_off) else $error("interface not off");

  property p_wake_on;
    @(posedge pclk) disable iff (!presetn)
      (!s.if_enabled && link_on_detect && !s.link_active) |=> s.wake ##1 $changed(s.wake_out);
  endproperty
  a_wake_on: assert property (p_wake_on) else $error("wake not raised");

  property p_lps_back;
    @(posedge pclk) disable iff (!presetn)
      link_power_status |=> (link_if_enabled && !link_if_reset);
  endproperty
  a_lps_back: assert property (p_lps_back) else $error("interface not back");

  property p_wake_off;
    @(posedge pclk) disable iff (!presetn)
      s.link_active |=> (!link_wake_signal && !s.wake);
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake still on");
endmodule

// File: hdl/phy_link_pkg.sv
// constants, types and helpers shared by the phy link power controller
// assumes a 20 MHz pclk and a 32-bit apb register bus
package phy_link_pkg;
  localparam int CLK_NS = 50;
  localparam int NUM_PORTS = 3;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SELFID = 8'h08;
  localparam logic [7:0] ADDR_GAP = 8'h0C;

  localparam int CTRL_SPEED_LSB = 0;
  localparam int CTRL_LACT_BIT = 2;
  localparam int CTRL_PEN_LSB = 4;
  localparam int CTRL_PSUS_LSB = 8;
  localparam logic [2:0] PORT_EN_RST = 3'h7;

  localparam int ST_LIF_LSB = 0;
  localparam int ST_WAKE_BIT = 2;
  localparam int ST_CONN_LSB = 4;
  localparam int ST_ACT_LSB = 8;
  localparam int ST_RXP_LSB = 12;

  localparam int SELFID_CONT_BIT = 20;
  localparam int SELFID_PC_LSB = 21;
  localparam logic [5:0] GAP_MAX = 6'h3F;
  localparam logic [1:0] PORT_NONE = 2'h3;

  localparam int LPS_RST_NS = 1200;
  localparam int LPS_DIS_NS = 25000;
  localparam int WAKE_HALF_NS = 82;
  localparam int RX_IDLE_NS = 400;
  localparam logic [9:0] LPS_RST_CYC = 10'(LPS_RST_NS / CLK_NS);
  localparam logic [9:0] LPS_DIS_CYC = 10'(LPS_DIS_NS / CLK_NS);
  localparam logic [3:0] WAKE_HALF_CYC =
    4'((WAKE_HALF_NS / CLK_NS) < 1 ? 1 : (WAKE_HALF_NS / CLK_NS));
  localparam logic [3:0] RX_IDLE_CYC = 4'((RX_IDLE_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {
    SPEED_S100 = 2'b00,
    SPEED_S200 = 2'b01,
    SPEED_S400 = 2'b10
  } speed_type;

  typedef enum logic [1:0] {
    LIF_ON = 2'b00,
    LIF_RESET = 2'b01,
    LIF_OFF = 2'b10
  } lif_state_type;

  function automatic logic [3:0] lines_for(input logic [1:0] sp);
    case (sp)
      SPEED_S100: lines_for = 4'd2;
      SPEED_S200: lines_for = 4'd4;
      default: lines_for = 4'd8;
    endcase
  endfunction
endpackage

// File: hdl/sync2.sv
// two-stage synchroniser for pin inputs
// assumes inputs are asynchronous to pclk
`timescale 1ns/1ns
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type s;
  sync_state_type next_s;

  always_comb begin
    next_s.meta = din;
    next_s.stable = s.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.stable;
endmodule

// File: hdl/phy_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock; ready and valid come straight from flops
`timescale 1ns/1ns
module phy_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
    logic in_ready;
    logic out_valid;
  } fifo_state_type;

  fifo_state_type s;
  fifo_state_type next_s;
  logic push;
  logic pop;

  always_comb begin
    next_s = s;
    push = in_valid && s.in_ready;
    pop = s.out_valid && out_ready;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr = (s.wr == LAST) ? '0 : s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = (s.rd == LAST) ? '0 : s.rd + 1'b1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
    next_s.in_ready = next_s.count != FULL;
    next_s.out_valid = next_s.count != '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.in_ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready = s.in_ready;
  assign out_valid = s.out_valid;
  assign out_data = s.mem[s.rd];

  property p_push;
    @(posedge pclk) disable iff (!presetn)
      (push && !pop) |=> (s.count == $past(s.count) + 1'b1);
  endproperty
  a_push: assert property (p_push) else $error("fifo push lost");
endmodule

// File: dv/link_model.sv
// link layer controller model: parallel tx lines and power status
// assumes the phy takes a word at a rising edge with valid and ready high
`timescale 1ns/1ns
module link_model (
  input wire logic pclk,
  input wire logic link_tx_ready,
  output logic [7:0] link_tx_data,
  output logic link_tx_valid,
  output logic link_power_status
);
  initial begin
    link_tx_data = 8'h00;
    link_tx_valid = 1'b0;
    link_power_status = 1'b1;
  end
  // powered link drives status high, powered down low
  task set_power(input logic on);
    link_power_status <= on;
  endtask
  // flag a word ready and hold it until taken
  task send(input logic [7:0] wd);
    link_tx_valid <= 1'b1;
    link_tx_data <= wd;
    do @(posedge pclk); while (link_tx_ready !== 1'b1);
  endtask
  // release; the lines no longer carry the last word
  task idle();
    link_tx_valid <= 1'b0;
    link_tx_data <= ~link_tx_data;
  endtask
endmodule

// File: dv/testbench.sv
// self-checking bench for the phy link power controller
// assumes link_model drives the parallel tx side and power status
`timescale 1ns/1ns
module testbench
  import phy_link_pkg::*;
();
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic link_on_detect = 1'b0;
  logic bm_contender = 1'b0;
  logic bus_reset_in = 1'b0;
  logic [2:0] port_data_in = 3'h0;
  logic [2:0] port_strobe_in = 3'h0;
  logic [2:0] port_connect = 3'h7;
  logic [2:0] power_class_inputs = 3'h0;
  logic [31:0] seed = 32'h5A;
  logic saw_full = 1'b0;
  logic pclk, pready, pslverr, err, link_clk, link_tx_ready, link_tx_valid, link_rx_valid;
  logic link_power_status, link_if_reset, link_if_enabled, link_wake_signal, prev, cur;
  logic [31:0] prdata, rd;
  logic [7:0] link_tx_data, link_rx_data, got, rx_word, m, w;
  logic [2:0] port_data_out, port_strobe_out, port_tx_oe_n, port_rx_en;
  int n_fail = 0;
  int check_count = 0;
  int ev, n_rx, bad, rxbad;

  serial_bus_phy_link_power_ctrl serial_bus_phy_link_power_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .link_tx_data(link_tx_data), .link_tx_valid(link_tx_valid),
    .link_tx_ready(link_tx_ready), .link_rx_data(link_rx_data),
    .link_rx_valid(link_rx_valid), .link_power_status(link_power_status),
    .link_on_detect(link_on_detect), .link_if_reset(link_if_reset),
    .link_if_enabled(link_if_enabled), .link_wake_signal(link_wake_signal),
    .port_data_in(port_data_in), .port_strobe_in(port_strobe_in),
    .port_connect(port_connect), .port_data_out(port_data_out),
    .port_strobe_out(port_strobe_out), .port_tx_oe_n(port_tx_oe_n), .port_rx_en(port_rx_en),
    .power_class_inputs(power_class_inputs), .bm_contender(bm_contender),
    .bus_reset_in(bus_reset_in)
  );
  link_model link_model_i (
    .pclk(pclk), .link_tx_ready(link_tx_ready), .link_tx_data(link_tx_data),
    .link_tx_valid(link_tx_valid), .link_power_status(link_power_status)
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (link_tx_ready === 1'b0) saw_full <= 1'b1;
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function logic [7:0] mask_of(input logic [1:0] sp);
    return sp == 2'h0 ? 8'h03 : (sp == 2'h1 ? 8'h0F : 8'hFF);
  endfunction

  function logic [31:0] selfid_exp(input logic c, input logic [2:0] pc);
    return {8'h00, pc, c, 20'h00000};
  endfunction

  task chk(input logic [31:0] g, input logic [31:0] e, input string msg);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask

  task complete_run();
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // apb transfer: setup, then access held until pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(pready, 1'b1, "no apb answer");
    @(posedge pclk);
  endtask

  task bus_rst(input logic v);
    bm_contender <= v;
    bus_reset_in <= v;
    repeat (4) @(posedge pclk);
  endtask

  // drive a word into port 1, log bit events on port 0, catch words to the link
  task run(input int cyc, input logic drv, input logic [7:0] wd, input int nb, input logic p2off);
    ev = 0;
    n_rx = 0;
    bad = 0;
    rxbad = 0;
    got = 8'h00;
    prev = port_data_out[0] ^ port_strobe_out[0];
    for (int k = 0; k < cyc; k++) begin
      if (drv && k < nb) begin
        if (wd[nb-1-k] !== port_data_in[1]) port_data_in[1] <= wd[nb-1-k];
        else port_strobe_in[1] <= ~port_strobe_in[1];
      end
      @(posedge pclk);
      cur = port_data_out[0] ^ port_strobe_out[0];
      if (cur !== prev && port_tx_oe_n[0] === 1'b0) begin
        ev++;
        got = {got[6:0], port_data_out[0]};
      end
      prev = cur;
      if (link_rx_valid === 1'b1) begin
        n_rx++;
        rx_word = link_rx_data;
      end
      if (p2off && (port_tx_oe_n[2] !== 1'b1 || port_rx_en[2] !== 1'b0)) bad++;
      if (drv && k == nb + 2 && (port_tx_oe_n !== 3'h2 || port_rx_en !== 3'h2)) rxbad++;
    end
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h70, "ctrl reset value");
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0, "unmapped read data");
    chk(err, 1'b1, "unmapped read error");
    for (int k = 0; k < 3; k++) begin
      w = 8'(rnd());
      power_class_inputs <= w[2:0];
      bus_rst(w[3]);
      apb(1'b0, ADDR_SELFID, 32'h0);
      chk(rd, selfid_exp(w[3], w[2:0]), "self-id bits");
    end
    bus_rst(1'b0);
    apb(1'b1, ADDR_GAP, 32'h5);
    bus_rst(1'b1);
    bus_rst(1'b0);
    apb(1'b0, ADDR_GAP, 32'h0);
    chk(rd, 32'h5, "gap after one bus reset");
    bus_rst(1'b1);
    bus_rst(1'b0);
    apb(1'b0, ADDR_GAP, 32'h0);
    chk(rd, 32'h3F, "gap after two bus resets");
    for (int sp = 0; sp < 3; sp++) begin
      m = mask_of(2'(sp));
      w = 8'(rnd()) & m;
      apb(1'b1, ADDR_CTRL, 32'h30 | 32'(sp));
      link_model_i.send(w);
      link_model_i.idle();
      run(30, 1'b0, 8'h00, 0, 1'b1);
      chk(ev, $countones(m), "tx bit count");
      chk(got, w, "tx bit values");
      chk(bad, 0, "disabled port active");
      apb(1'b1, ADDR_CTRL, 32'h70 | 32'(sp));
      w = 8'(rnd()) & m;
      run(30, 1'b1, w, $countones(m), 1'b0);
      chk({n_rx[1:0], rx_word & m}, {2'h1, w}, "rx word");
      chk(ev, $countones(m), "repeat count");
      chk(rxbad, 0, "receiving port drivers");
    end
    port_connect <= 3'h5;
    repeat (4) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[6:4], 3'h5, "connect state");
    chk(rd[10:8], 3'h5, "active ports");
    port_connect <= 3'h7;
    for (int k = 0; k < 14; k++) link_model_i.send(8'(rnd()));
    link_model_i.idle();
    chk(saw_full, 1'b1, "fifo never refused");
    repeat (200) @(posedge pclk);
    chk(link_tx_ready, 1'b1, "fifo not drained");
    link_model_i.set_power(1'b0);
    repeat (30) @(posedge pclk);
    chk({link_if_reset, link_if_enabled}, 2'h3, "short power loss");
    link_model_i.set_power(1'b1);
    repeat (3) @(posedge pclk);
    chk({link_if_reset, link_if_enabled}, 2'h1, "power back");
    link_model_i.set_power(1'b0);
    repeat (520) @(posedge pclk);
    chk(link_if_enabled, 1'b0, "long power loss");
    run(30, 1'b1, 8'hA5, 8, 1'b0);
    chk(ev, 32'd8, "repeat while link off");
    chk(n_rx, 32'd0, "word passed while link off");
    link_on_detect <= 1'b1;
    @(posedge pclk);
    link_on_detect <= 1'b0;
    repeat (3) @(posedge pclk);
    for (int k = 0; k < 3; k++) begin
      prev = link_wake_signal;
      cur = link_clk;
      @(posedge pclk);
      chk(link_wake_signal, !prev, "wake not toggling");
      chk(link_clk, !cur, "link clock not running");
    end
    link_model_i.set_power(1'b1);
    repeat (3) @(posedge pclk);
    chk(link_if_enabled, 1'b1, "link not re-enabled");
    apb(1'b1, ADDR_CTRL, 32'h76);
    @(posedge pclk);
    chk(link_wake_signal, 1'b0, "wake after active bit");
    @(posedge pclk);
    chk(link_wake_signal, 1'b0, "wake after active bit");
    complete_run();
  end

  initial begin
    repeat (8000) @(posedge pclk);
    n_fail++;
    complete_run();
  end
endmodule
